// ---- rtl/cie_pkg.sv ----
package cie_pkg;

   // Register byte addresses on the APB.
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_FLAGS   = 8'h08;
   localparam logic [7:0] ADDR_PAIR0   = 8'h0C;
   localparam logic [7:0] ADDR_VECBASE = 8'h24;
   localparam logic [7:0] ADDR_SERVICE = 8'h28;
   localparam int         NUM_PAIRS    = 6;

   // Pair indices; a pair at index k sits at ADDR_PAIR0 + 4*k.
   localparam logic [2:0] PIX_FIRST   = 3'd0;
   localparam logic [2:0] PIX_SECOND  = 3'd1;
   localparam logic [2:0] PIX_PRIMARY = 3'd2;
   localparam logic [2:0] PIX_STACK   = 3'd3;
   localparam logic [2:0] PIX_INDEX1  = 3'd4;
   localparam logic [2:0] PIX_INDEX2  = 3'd5;

   // Control register fields.
   localparam int CTRL_OP_LSB  = 0;
   localparam int CTRL_PFX_LSB = 8;
   localparam int CTRL_GO_BIT  = 16;

   // Prefix and opcode bytes.
   localparam logic [7:0] PFX_NONE   = 8'h00;
   localparam logic [7:0] PFX_ED     = 8'hED;
   localparam logic [7:0] PFX_DD     = 8'hDD;
   localparam logic [7:0] PFX_FD     = 8'hFD;
   localparam logic [7:0] OP_EI      = 8'hFB;
   localparam logic [7:0] OP_IM0     = 8'h46;
   localparam logic [7:0] OP_IM1     = 8'h56;
   localparam logic [7:0] OP_IM2     = 8'h5E;
   localparam logic [7:0] OP_INC_IDX = 8'h23;
   localparam logic [1:0] SEL_SELF   = 2'b10;

   localparam logic [15:0] RESTART_ADDR = 16'h0038;

   // Clock states per instruction (one ref_clk cycle each).
   localparam logic [4:0] T_EI      = 5'd4;
   localparam logic [4:0] T_IM      = 5'd8;
   localparam logic [4:0] T_ADD     = 5'd11;
   localparam logic [4:0] T_WIDE    = 5'd15;
   localparam logic [4:0] T_INC     = 5'd6;
   localparam logic [4:0] T_INC_IDX = 5'd10;
   localparam logic [4:0] T_NOP     = 5'd4;
   localparam logic [4:0] ACK_CYCLES = 5'd3;

   // Reset values.
   localparam logic [15:0] RST_PAIR  = 16'h0000;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;

   typedef enum logic [1:0] {
      CIE_IM0 = 2'b00,
      CIE_IM1 = 2'b01,
      CIE_IM2 = 2'b10
   } cie_imode_e;

   typedef enum logic [2:0] {
      CIE_IDLE = 3'b000,
      CIE_EXEC = 3'b001,
      CIE_ACK  = 3'b010,
      CIE_VLO  = 3'b011,
      CIE_VHI  = 3'b100,
      CIE_VEND = 3'b101
   } cie_state_e;

   typedef struct packed {
      logic s;
      logic z;
      logic y5;
      logic h;
      logic y3;
      logic pv;
      logic n;
      logic c;
   } cie_flags_s;

endpackage

// ---- rtl/cie_exec.sv ----
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - No maskable interrupt until instruction after enable
// - Enable sets both interrupt enable latches
// - ED 46 selects mode 0, byte taken
// - ED 56 selects mode 1, restart 0038H
// - Mode 2 pointer from base and vector
// - Mode select takes eight clock states
// - 00ss1001 adds selected pair to primary pair
// - Plain add: H bit 11, C bit 15
// - Plain add takes eleven clock states
// - ED 01ss1010 adds pair plus carry
// - Add-with-carry sets all arithmetic flags
// - ED 01ss0010 subtracts pair and carry
// - Subtract flags: borrow bit 12, N set
// - Carry add and subtract take fifteen states
// - DD 00pp1001 adds pair to first index
// - FD 00rr1001 adds pair to second index
// - 00ss0011 increments pair, six states, flags kept
// - DD 23 increments first index, ten states
module cie_exec (
   // Clock, reset and enable
   input  wire  logic        ref_clk,
   input  wire  logic        nrst,
   input  wire  logic        ce,
   // APB slave
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Interrupt pins
   input  wire  logic        irq_n,
   input  wire  logic [7:0]  data_bus_in,
   output logic              irq_ack,
   // Vector table read port, data one cycle after mem_rd
   output logic              mem_rd,
   output logic [15:0]       mem_addr,
   input  wire  logic [7:0]  mem_rd_data
);

   cie_pkg::cie_state_e state;
   cie_pkg::cie_imode_e imode;
   cie_pkg::cie_flags_s flags;
   cie_pkg::cie_flags_s next_flags;

   logic [15:0] pair [cie_pkg::NUM_PAIRS];
   logic [7:0]  op;
   logic [7:0]  pfx;
   logic [4:0]  cnt;
   logic [7:0]  vec_base;
   logic [7:0]  vector;
   logic [7:0]  mode0_byte;
   logic [15:0] service;
   logic        irq_enable_latch;
   logic        irq_enable_shadow;
   logic        ei_block;
   logic        taken;
   logic        illegal;
   logic [1:0]  irq_meta;
   logic [7:0]  bus_meta;
   logic [7:0]  bus_sync;
   logic        irq_sync_n;
   logic [31:0] rd_mux;

   // APB decode.
   wire         acc       = psel & penable;
   wire         wr        = acc & pwrite;
   wire [7:0]   pair_off  = paddr - cie_pkg::ADDR_PAIR0;
   wire         pair_hit  = (paddr >= cie_pkg::ADDR_PAIR0)
                          & (paddr < cie_pkg::ADDR_VECBASE)
                          & (paddr[1:0] == 2'b00);
   wire [2:0]   pair_sel  = pair_off[4:2];
   wire         hit       = pair_hit
                          | (paddr == cie_pkg::ADDR_CTRL)
                          | (paddr == cie_pkg::ADDR_STATUS)
                          | (paddr == cie_pkg::ADDR_FLAGS)
                          | (paddr == cie_pkg::ADDR_VECBASE)
                          | (paddr == cie_pkg::ADDR_SERVICE);
   wire         idle      = (state == cie_pkg::CIE_IDLE);
   wire         go        = wr & (paddr == cie_pkg::ADDR_CTRL)
                          & pwdata[cie_pkg::CTRL_GO_BIT] & idle;
   wire         sw_wr     = wr & idle;
   wire         svc_clear = wr & (paddr == cie_pkg::ADDR_SERVICE);

   // Instruction decode.
   wire         np   = (pfx == cie_pkg::PFX_NONE);
   wire         ed   = (pfx == cie_pkg::PFX_ED);
   wire         dd   = (pfx == cie_pkg::PFX_DD);
   wire         fd   = (pfx == cie_pkg::PFX_FD);
   wire [1:0]   ss   = op[5:4];
   wire         is_ei   = np & (op == cie_pkg::OP_EI);
   wire         is_im0  = ed & (op == cie_pkg::OP_IM0);
   wire         is_im1  = ed & (op == cie_pkg::OP_IM1);
   wire         is_im2  = ed & (op == cie_pkg::OP_IM2);
   wire         is_add  = np & (op[7:6] == 2'b00) & (op[3:0] == 4'h9);
   wire         is_adc  = ed & (op[7:6] == 2'b01) & (op[3:0] == 4'hA);
   wire         is_sbc  = ed & (op[7:6] == 2'b01) & (op[3:0] == 4'h2);
   wire         is_addx = (dd | fd) & (op[7:6] == 2'b00)
                        & (op[3:0] == 4'h9);
   wire         is_inc  = np & (op[7:6] == 2'b00) & (op[3:0] == 4'h3);
   wire         is_incx = (dd | fd) & (op == cie_pkg::OP_INC_IDX);
   wire         is_im   = is_im0 | is_im1 | is_im2;
   wire         known   = is_ei | is_im | is_add | is_adc | is_sbc
                        | is_addx | is_inc | is_incx;

   // The pair that receives the result; code 10 names it as a source.
   wire [2:0]   acc_idx = dd ? cie_pkg::PIX_INDEX1
                        : fd ? cie_pkg::PIX_INDEX2
                        : cie_pkg::PIX_PRIMARY;
   wire [2:0]   src_idx = (ss == cie_pkg::SEL_SELF) ? acc_idx
                        : {1'b0, ss};
   wire [2:0]   dst_idx = is_inc ? {1'b0, ss} : acc_idx;
   wire [15:0]  a       = pair[dst_idx];
   wire [15:0]  b       = pair[src_idx];
   wire         cin     = (is_adc | is_sbc) & flags.c;

   wire [16:0]  sum17   = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
   wire [16:0]  dif17   = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
   wire [12:0]  sum13   = {1'b0, a[11:0]} + {1'b0, b[11:0]}
                        + {12'h000, cin};
   wire [12:0]  dif13   = {1'b0, a[11:0]} - {1'b0, b[11:0]}
                        - {12'h000, cin};
   wire [15:0]  inc16   = a + 16'h0001;
   wire [15:0]  res     = is_sbc ? dif17[15:0]
                        : (is_inc | is_incx) ? inc16 : sum17[15:0];
   wire         ovf_add = (a[15] == b[15]) & (sum17[15] != a[15]);
   wire         ovf_sub = (a[15] != b[15]) & (dif17[15] != a[15]);
   wire         writes  = is_add | is_adc | is_sbc | is_addx
                        | is_inc | is_incx;

   wire [4:0]   tlen = is_ei ? cie_pkg::T_EI
                     : is_im ? cie_pkg::T_IM
                     : is_add ? cie_pkg::T_ADD
                     : (is_adc | is_sbc) ? cie_pkg::T_WIDE
                     : is_addx ? cie_pkg::T_WIDE
                     : is_inc ? cie_pkg::T_INC
                     : is_incx ? cie_pkg::T_INC_IDX
                     : cie_pkg::T_NOP;
   wire         last    = (state == cie_pkg::CIE_EXEC)
                        & (cnt == tlen - 5'd1);
   wire         ack_end = (state == cie_pkg::CIE_ACK)
                        & (cnt == cie_pkg::ACK_CYCLES - 5'd1);
   // An accepted request waits out the instruction after the enable.
   wire         accept  = idle & ~go & ~irq_sync_n & irq_enable_latch
                        & ~ei_block;
   wire [15:0]  tbl_ptr = {vec_base, vector};

   always_comb begin
      next_flags = flags;
      if (is_add | is_addx) begin
         next_flags.h = sum13[12];
         next_flags.c = sum17[16];
         next_flags.n = 1'b0;
      end else if (is_adc) begin
         next_flags.s  = res[15];
         next_flags.z  = (res == 16'h0000);
         next_flags.h  = sum13[12];
         next_flags.pv = ovf_add;
         next_flags.n  = 1'b0;
         next_flags.c  = sum17[16];
      end else if (is_sbc) begin
         next_flags.s  = res[15];
         next_flags.z  = (res == 16'h0000);
         next_flags.h  = dif13[12];
         next_flags.pv = ovf_sub;
         next_flags.n  = 1'b1;
         next_flags.c  = dif17[16];
      end
   end

   // Pin inputs pass two flip-flops before any logic reads them.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         irq_meta <= 2'b11;
         bus_meta <= cie_pkg::RST_BYTE;
         bus_sync <= cie_pkg::RST_BYTE;
      end else if (ce) begin
         irq_meta <= {irq_meta[0], irq_n};
         bus_meta <= data_bus_in;
         bus_sync <= bus_meta;
      end
   end
   assign irq_sync_n = irq_meta[1];

   // Pair file; software writes are refused while an operation runs.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int i = 0; i < cie_pkg::NUM_PAIRS; i++) begin
            pair[i] <= cie_pkg::RST_PAIR;
         end
      end else if (ce) begin
         if (last & writes) begin
            pair[dst_idx] <= res;
         end else if (sw_wr & pair_hit) begin
            pair[pair_sel] <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state             <= cie_pkg::CIE_IDLE;
         imode             <= cie_pkg::CIE_IM0;
         flags             <= '0;
         op                <= cie_pkg::RST_BYTE;
         pfx               <= cie_pkg::RST_BYTE;
         cnt               <= 5'd0;
         vec_base          <= cie_pkg::RST_BYTE;
         vector            <= cie_pkg::RST_BYTE;
         mode0_byte        <= cie_pkg::RST_BYTE;
         service           <= cie_pkg::RST_PAIR;
         mem_addr          <= cie_pkg::RST_PAIR;
         irq_enable_latch  <= 1'b0;
         irq_enable_shadow <= 1'b0;
         ei_block          <= 1'b0;
         taken             <= 1'b0;
         illegal           <= 1'b0;
      end else if (ce) begin
         cnt <= cnt + 5'd1;
         if (sw_wr & (paddr == cie_pkg::ADDR_FLAGS)) begin
            flags <= pwdata[7:0];
         end
         if (sw_wr & (paddr == cie_pkg::ADDR_VECBASE)) begin
            vec_base <= pwdata[7:0];
         end
         // A service completion in the clearing cycle keeps the flag set.
         if (svc_clear) begin
            taken <= 1'b0;
         end
         case (state)
            cie_pkg::CIE_IDLE: begin
               cnt <= 5'd0;
               if (go) begin
                  op    <= pwdata[cie_pkg::CTRL_OP_LSB +: 8];
                  pfx   <= pwdata[cie_pkg::CTRL_PFX_LSB +: 8];
                  state <= cie_pkg::CIE_EXEC;
               end else if (accept) begin
                  irq_enable_latch  <= 1'b0;
                  irq_enable_shadow <= 1'b0;
                  state             <= cie_pkg::CIE_ACK;
               end
            end
            cie_pkg::CIE_EXEC: begin
               if (last) begin
                  state    <= cie_pkg::CIE_IDLE;
                  flags    <= next_flags;
                  illegal  <= ~known;
                  ei_block <= is_ei;
                  if (is_ei) begin
                     irq_enable_latch  <= 1'b1;
                     irq_enable_shadow <= 1'b1;
                  end
                  if (is_im0) imode <= cie_pkg::CIE_IM0;
                  if (is_im1) imode <= cie_pkg::CIE_IM1;
                  if (is_im2) imode <= cie_pkg::CIE_IM2;
               end
            end
            cie_pkg::CIE_ACK: begin
               if (ack_end) begin
                  cnt <= 5'd0;
                  case (imode)
                     cie_pkg::CIE_IM0: begin
                        mode0_byte <= bus_sync;
                        taken      <= 1'b1;
                        state      <= cie_pkg::CIE_IDLE;
                     end
                     cie_pkg::CIE_IM1: begin
                        service <= cie_pkg::RESTART_ADDR;
                        taken   <= 1'b1;
                        state   <= cie_pkg::CIE_IDLE;
                     end
                     default: begin
                        vector   <= bus_sync;
                        mem_addr <= {vec_base, bus_sync};
                        state    <= cie_pkg::CIE_VLO;
                     end
                  endcase
               end
            end
            cie_pkg::CIE_VLO: begin
               mem_addr <= tbl_ptr + 16'h0001;
               state    <= cie_pkg::CIE_VHI;
            end
            cie_pkg::CIE_VHI: begin
               service[7:0] <= mem_rd_data;
               state        <= cie_pkg::CIE_VEND;
            end
            cie_pkg::CIE_VEND: begin
               service[15:8] <= mem_rd_data;
               taken         <= 1'b1;
               state         <= cie_pkg::CIE_IDLE;
            end
            default: state <= cie_pkg::CIE_IDLE;
         endcase
      end
   end

   assign irq_ack = (state == cie_pkg::CIE_ACK);
   assign mem_rd  = (state == cie_pkg::CIE_VLO)
                  | (state == cie_pkg::CIE_VHI);

   // Read data is registered in the setup phase so the zero-wait access
   // phase presents it from a flip-flop.
   assign rd_mux = pair_hit ? {16'h0000, pair[pair_sel]}
      : (paddr == cie_pkg::ADDR_CTRL) ? {16'h0000, pfx, op}
      : (paddr == cie_pkg::ADDR_STATUS)
         ? {8'h00, vector, mode0_byte, illegal, ei_block, taken,
            irq_enable_shadow, irq_enable_latch, imode, ~idle}
      : (paddr == cie_pkg::ADDR_FLAGS) ? {24'h000000, flags}
      : (paddr == cie_pkg::ADDR_VECBASE) ? {24'h000000, vec_base}
      : (paddr == cie_pkg::ADDR_SERVICE) ? {16'h0000, service}
      : cie_pkg::RST_WORD;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         prdata <= cie_pkg::RST_WORD;
      end else if (ce && psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;

endmodule

`default_nettype wire

// ---- test/cie_exec_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module cie_exec_monitor (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        nrst,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Interrupt and table read
   input wire logic        irq_n,
   input wire logic [7:0]  data_bus_in,
   input wire logic        irq_ack,
   input wire logic        mem_rd,
   input wire logic [15:0] mem_addr
);
   logic [7:0] bus_d1;
   logic [7:0] bus_d2;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // Mirror of the pin synchroniser, so the vector can be traced to the pins.
   always_ff @(posedge ref_clk) begin
      bus_d1 <= data_bus_in;
      bus_d2 <= bus_d1;
   end
   sequence s_ack;
      irq_ack [*3] ##1 !irq_ack;
   endsequence
   sequence s_tbl;
      mem_rd [*2] ##1 !mem_rd;
   endsequence
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (pslverr == (psel && penable &&
      (paddr > 8'h28 || paddr[1:0] != 2'h0)))
      else $error("pslverr wrong");
   a_rdata_hold: assert property (!psel |=> $stable(prdata))
      else $error("prdata moved while idle");
   a_ack_frame: assert property ($rose(irq_ack) |-> s_ack)
      else $error("acknowledge not three cycles");
   // The request passes two flip-flops and one accepting cycle first.
   a_ack_cause: assert property ($rose(irq_ack) |-> !$past(irq_n, 3))
      else $error("acknowledge without request");
   a_tbl_after: assert property (
      $rose(mem_rd) |-> $past(irq_ack) ##0 s_tbl)
      else $error("table read not two cycles after acknowledge");
   a_tbl_step: assert property ($rose(mem_rd) |=>
      mem_addr == $past(mem_addr) + 16'h0001)
      else $error("table high byte address wrong");
   a_tbl_vector: assert property ($rose(mem_rd) |->
      mem_addr[7:0] == $past(bus_d2))
      else $error("table low byte is not the vector");
endmodule
`default_nettype wire

// ---- test/cie_periph.sv ----
`timescale 1ns/10ps
`default_nettype none
module cie_periph (
   // Bench controls
   input wire logic        ref_clk,
   input wire logic        irq_req,
   input wire logic [7:0]  vec,
   // Core side
   input wire logic        irq_ack,
   input wire logic        mem_rd,
   input wire logic [15:0] mem_addr,
   output logic            irq_n,
   output logic [7:0]      data_bus_in,
   output logic [7:0]      mem_rd_data
);
   logic [7:0] rd_q = 8'h00;
   assign irq_n       = !irq_req;
   // A released bus shows the inverse byte, so an early sample is caught.
   assign data_bus_in = irq_ack ? vec : ~vec;
   assign mem_rd_data = rd_q;
   // Table bytes depend on both address halves, so the base is checked too.
   always @(posedge ref_clk) begin
      rd_q <= mem_rd ? mem_addr[7:0] + mem_addr[15:8] : ~rd_q;
   end
endmodule
`default_nettype wire

// ---- test/test_cie_exec.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_cie_exec;
   localparam logic [15:0] P [0:5] = '{16'h2222, 16'h1111, 16'h5437,
                                       16'h8800, 16'h0333, 16'hFFFF};
   // Each entry: prefix, opcode, starting flags, clock states.
   localparam logic [31:0] CASES [0:22] = '{
      32'h0009_000B, 32'h0019_C50B, 32'h0029_000B, 32'h0039_C50B,
      32'hED4A_C50F, 32'hED5A_000F, 32'hED6A_C50F, 32'hED7A_000F,
      32'hED42_000F, 32'hED52_C50F, 32'hED62_000F, 32'hED72_C50F,
      32'hDD09_000F, 32'hDD29_C50F, 32'hFD19_000F, 32'hFD29_C50F,
      32'hFD39_000F, 32'h0003_C506, 32'h0013_0006, 32'h0023_C506,
      32'h0033_0006, 32'hDD23_C50A, 32'hFD23_000A};
   logic        ref_clk = 1'b0, nrst = 1'b0, ce = 1'b1, irq_req = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack_q = 1'b0;
   logic [7:0]  paddr = 8'h00, vec = 8'h00, data_bus_in, mem_rd_data;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, irq_n, irq_ack, mem_rd, e;
   logic [15:0] mem_addr;
   int          n_errors = 0, n_tests = 0, n_ack = 0;

   cie_exec u_dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_n(irq_n),
      .data_bus_in(data_bus_in), .irq_ack(irq_ack), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_rd_data(mem_rd_data));
   cie_periph u_peer (.ref_clk(ref_clk), .irq_req(irq_req), .vec(vec),
      .irq_ack(irq_ack), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .irq_n(irq_n), .data_bus_in(data_bus_in), .mem_rd_data(mem_rd_data));

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      ack_q <= irq_ack;
      if (irq_ack && !ack_q)
         n_ack++;
   end
   initial begin
      #250000;
      n_errors++;
      results;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("errors %0d of %0d checks", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // An idle edge first, so a release and the next request never collide.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Busy is sampled in the last state, or in the one after when late.
   task automatic ex(input logic [15:0] o, input int n, input logic late);
      apb(1'b1, cie_pkg::ADDR_CTRL, {15'h0, 1'b1, o}, r);
      repeat (n - 2 + int'(late)) @(posedge ref_clk);
      apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0, r);
      chk(32'(r[0]), 32'(!late));
   endtask
   task automatic s_regs;
      apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0, r);
      chk(r, 32'h0);
      apb(1'b0, cie_pkg::ADDR_FLAGS, 32'h0, r);
      chk(r, 32'h0);
      apb(1'b1, 8'h2C, 32'hFFFF_FFFF, r);
      chk(32'(e), 32'h1);
      apb(1'b0, 8'h2C, 32'h0, r);
      chk({r[30:0], e}, 32'h1);
   endtask
   task automatic s_irq(input logic [7:0] mop, input logic [1:0] m,
      input logic [7:0] v, input logic [15:0] svc, input logic defer);
      int a0;
      vec <= v;
      apb(1'b1, cie_pkg::ADDR_SERVICE, 32'h0, r);
      ex({8'hED, mop}, 8, 1'b0);
      ex(16'h00FB, 4, 1'b1);
      apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0, r);
      chk(32'(r[6:1]), 32'({4'hB, m}));
      a0 = n_ack;
      // While idle after the enable, a pending request must still wait.
      irq_req <= defer;
      repeat (6) @(posedge ref_clk);
      chk(n_ack, a0);
      ex(16'h0009, 11, 1'b0);
      chk(n_ack, a0);
      irq_req <= 1'b1;
      for (int k = 0; k < 40 && n_ack == a0; k++) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
      irq_req <= 1'b0;
      chk(n_ack, a0 + 1);
      apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0, r);
      chk(32'(r[6:1]), 32'({4'h4, m}));
      if (m == 2'h0)
         chk(32'(r[15:8]), 32'(v));
      if (m == 2'h2)
         chk(32'(r[23:16]), 32'(v));
      apb(1'b0, cie_pkg::ADDR_SERVICE, 32'h0, r);
      if (m != 2'h0)
         chk(r, 32'(svc));
   endtask
   // An unknown code, a mode 0 select and a run frozen by the clock enable.
   task automatic s_tail;
      ex(16'h0000, 4, 1'b1);
      ex(16'hED46, 8, 1'b0);
      apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0, r);
      chk(32'(r[2:1]), 32'h0);
      apb(1'b1, cie_pkg::ADDR_CTRL, 32'h0001_0003, r);
      ce <= 1'b0;
      repeat (5) @(posedge ref_clk);
      ce <= 1'b1;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0, r);
      chk(32'(r[0]), 32'h1);
   endtask
   task automatic s_arith;
      logic [15:0] a, b, o;
      logic [15:0] pe [0:5];
      logic [16:0] s;
      logic [7:0]  f, fe;
      int          d;
      for (int i = 0; i < 23; i++) begin
         o = CASES[i][31:16];
         f = CASES[i][15:8];
         for (int k = 0; k < 6; k++) begin
            pe[k] = P[k];
            apb(1'b1, cie_pkg::ADDR_PAIR0 + 8'(4 * k), 32'(P[k]), r);
         end
         apb(1'b1, cie_pkg::ADDR_FLAGS, 32'(f), r);
         ex(o, int'(CASES[i][7:0]), i[0]);
         d = (o[15:8] == 8'hDD) ? 4 : (o[15:8] == 8'hFD) ? 5 : 2;
         if (o[3:0] == 4'h3 && o[15:8] == 8'h00)
            d = int'(o[5:4]);
         a = pe[d];
         b = (o[5:4] == 2'h2) ? a : pe[o[5:4]];
         fe = f;
         if (o[3:0] == 4'h3)
            pe[d] = a + 16'h0001;
         else if (o[15:8] != 8'hED) begin
            s = a + b;
            pe[d] = s[15:0];
            fe = {f[7:6], 1'b0, ^{a[12], b[12], s[12]}, 1'b0, f[2], 1'b0,
                  s[16]};
         end else begin
            s = o[3] ? a + b + f[0] : {1'b0, a} - b - f[0];
            pe[d] = s[15:0];
            fe = {s[15], s[15:0] == 16'h0, 1'b0, ^{a[12], b[12], s[12]},
                  1'b0, (a[15] ^ b[15] ^ o[3]) & (s[15] ^ a[15]), !o[3],
                  s[16]};
         end
         for (int k = 0; k < 6; k++) begin
            apb(1'b0, cie_pkg::ADDR_PAIR0 + 8'(4 * k), 32'h0, r);
            chk(r, 32'(pe[k]));
         end
         apb(1'b0, cie_pkg::ADDR_FLAGS, 32'h0, r);
         chk(r & 32'hD7, 32'(fe & 8'hD7));
      end
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      s_regs;
      s_irq(8'h46, 2'h0, 8'h3C, 16'h0000, 1'b0);
      s_irq(8'h56, 2'h1, 8'hA7, 16'h0038, 1'b1);
      apb(1'b1, cie_pkg::ADDR_VECBASE, 32'h0000_005A, r);
      s_irq(8'h5E, 2'h2, 8'h40, 16'h9B9A, 1'b0);
      s_arith;
      apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0, r);
      chk(32'(r[2:1]), 32'h2);
      s_tail;
      results;
   end
endmodule

bind cie_exec cie_exec_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq_n(irq_n),
   .data_bus_in(data_bus_in), .irq_ack(irq_ack), .mem_rd(mem_rd),
   .mem_addr(mem_addr));
`default_nettype wire
